// File: shared/rcl_pkg.sv
// Shared constants and types of the reset pin and configuration latch
package rcl_pkg;

    // Timing: one half-clock unit is half a CPU clock period
    localparam int CLK_PERIOD_NS = 10;
    localparam int HALF_UNIT_NS  = CLK_PERIOD_NS / 2;
    localparam int UNITS_PER_CYC = CLK_PERIOD_NS / HALF_UNIT_NS;
    localparam int SEQ_UNITS     = 1024;
    localparam int LATCH_UNITS   = 8;
    localparam int LATCH_BYP_UNITS = 6;
    localparam int CNT_W         = 10;
    localparam logic [CNT_W-1:0] SEQ_CYC =
        CNT_W'((SEQ_UNITS + UNITS_PER_CYC - 1) / UNITS_PER_CYC);
    localparam logic [CNT_W-1:0] LATCH_CYC =
        CNT_W'((LATCH_UNITS + UNITS_PER_CYC - 1) / UNITS_PER_CYC);
    localparam logic [CNT_W-1:0] LATCH_BYP_CYC =
        CNT_W'((LATCH_BYP_UNITS + UNITS_PER_CYC - 1) / UNITS_PER_CYC);

    // Register offsets
    localparam logic [7:0] OFS_SYSCFG  = 8'h00;
    localparam logic [7:0] OFS_BUSCTL0 = 8'h04;
    localparam logic [7:0] OFS_RSTCFG  = 8'h08;
    localparam logic [7:0] OFS_STATUS  = 8'h0c;

    // system_config_reg fields
    localparam int SYS_BIDIR_BIT   = 3;
    localparam int SYS_POWERDOWN_INTERRUPTIBLE_CFG_BIT  = 5;
    localparam int SYS_WRSIG_BIT   = 7;
    localparam int SYS_BYTE_HIGH_DISABLE_BIT  = 9;
    localparam logic [15:0] SYS_RST = 16'h0000;

    // bus_control_reg0 fields
    localparam int BUS_TYPE_LSB    = 6;
    localparam int BUS_LATCH_BIT   = 9;
    localparam int BUS_ACTIVE_BIT  = 10;
    localparam logic [15:0] BUS_RST = 16'h0000;

    // Config port sampling per reset kind, and bits cleared instead
    localparam logic [15:0] MASK_FULL  = 16'hffff;
    localparam logic [15:0] MASK_SHORT = 16'h1fff;
    localparam logic [15:0] MASK_SOFT  = 16'h1fc0;
    localparam logic [15:0] CLR_SOFT   = 16'h003c;
    localparam logic [15:0] CFG_RST    = 16'h0000;

    typedef enum logic [2:0] {
        RK_POWERON,
        RK_LONG_HW,
        RK_SHORT_HW,
        RK_SOFTWARE,
        RK_WATCHDOG
    } rcl_kind_e;

endpackage

// File: rtl/rcl_sampler.sv
// Configuration port sampler: keeps the bits picked by the reset kind
`timescale 1ns/1ps
module rcl_sampler #(
    parameter int WIDTH = 16
) (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rst,
    input  wire logic                  i_strobe,
    input  wire rcl_pkg::rcl_kind_e    i_kind,
    input  wire logic [WIDTH-1:0]      i_config_port,
    output logic      [WIDTH-1:0]      o_latched
);

    function automatic logic [15:0] sample_mask(rcl_pkg::rcl_kind_e k);
        unique case (k)
            rcl_pkg::RK_POWERON,
            rcl_pkg::RK_LONG_HW:  sample_mask = rcl_pkg::MASK_FULL;
            rcl_pkg::RK_SHORT_HW: sample_mask = rcl_pkg::MASK_SHORT;
            default:              sample_mask = rcl_pkg::MASK_SOFT;
        endcase
    endfunction

    wire logic [15:0] mask_bits;
    wire logic [15:0] clr_bits;
    wire logic        soft_kind;

    assign soft_kind = (i_kind == rcl_pkg::RK_SOFTWARE) ||
                       (i_kind == rcl_pkg::RK_WATCHDOG);
    assign mask_bits = sample_mask(i_kind);
    assign clr_bits  = soft_kind ? rcl_pkg::CLR_SOFT : 16'h0000;

    // Unsampled bits hold their old value until a reset samples them, except bits 5:2, which a software or watchdog reset clears
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge i_clk_sys or posedge i_rst) begin
                if (i_rst) begin
                    o_latched[g] <= rcl_pkg::CFG_RST[g];
                end else if (i_strobe && mask_bits[g]) begin
                    o_latched[g] <= i_config_port[g];
                end else if (i_strobe && clr_bits[g]) begin
                    o_latched[g] <= 1'b0;
                end
            end
        end
    endgenerate

    soft_keeps_high_a: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        (i_strobe && soft_kind) |=> $stable(o_latched[15:13]))
        else $error("soft reset changed clock option bits");

    cfg_stable_a: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        !i_strobe |=> $stable(o_latched))
        else $error("latched config changed without a strobe");

endmodule

// File: rtl/rcl_top.sv
// Reset pin driver, discharge pin control and configuration latch
`timescale 1ns/1ps
module rcl_top (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic        i_reset_in_pin,
    output logic             o_reset_in_pin_out,
    output logic             o_reset_in_pin_oe,
    input  wire logic        i_discharge_pin_high,
    output logic             o_discharge_pull_down,
    output logic             o_discharge_pull_up,
    output logic             o_reset_out_pin_n,
    input  wire logic        i_sw_reset_req,
    input  wire logic        i_wdt_reset_req,
    input  wire logic        i_end_of_init_instr,
    input  wire logic        i_pll_bypass,
    input  wire logic        i_external_access_pin,
    input  wire logic [15:0] i_config_port,
    input  wire logic [7:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    output logic             o_cpu_reset,
    output logic             o_async_reset,
    output logic      [2:0]  o_clock_option_bits,
    output logic      [1:0]  o_segment_line_select,
    output logic      [1:0]  o_chip_select_count,
    output logic             o_write_pin_config,
    output logic             o_bootloader_select,
    output logic             o_adapt_select,
    output logic             o_emu_mode
);

    typedef enum logic [2:0] {
        S_RUN,
        S_SEQ,
        S_CHECK,
        S_WAITPIN,
        S_LATCH
    } rcl_state_e;

    localparam int CW = rcl_pkg::CNT_W;

    rcl_state_e          state;
    rcl_state_e          next_state;
    rcl_pkg::rcl_kind_e  kind;
    rcl_pkg::rcl_kind_e  next_kind;
    logic [CW-1:0]       cnt;
    logic                drive_en;
    logic                pull_up_en;
    logic                init_done;
    logic                byp_q;
    logic [15:0]         system_config_reg;
    logic [15:0]         bus_control_reg0;
    logic [15:0]         latched;

    wire logic           pin_low;
    wire logic           hw_start;
    wire logic           wdt_start;
    wire logic           sw_start;
    wire logic           seq_start;
    wire logic           seq_last;
    wire logic           latch_strobe;
    wire logic           rpd_drop;
    wire logic [CW-1:0]  latch_len;
    wire logic           wr_sys;
    wire logic           wr_bus;
    wire logic [15:0]    reset_config_latch;
    wire logic [15:0]    bus_read;
    wire logic [15:0]    status_read;
    wire logic [15:0]    rd_mux;

    // Start conditions; the pin wins over internal requests
    assign pin_low   = !i_reset_in_pin;
    assign hw_start  = (state == S_RUN) && pin_low;
    assign wdt_start = (state == S_RUN) && !pin_low && i_wdt_reset_req;
    assign sw_start  = (state == S_RUN) && !pin_low && !i_wdt_reset_req &&
                       i_sw_reset_req;
    assign seq_start = hw_start || wdt_start || sw_start;
    assign seq_last  = (state == S_SEQ) && (cnt == rcl_pkg::SEQ_CYC - 1'b1);
    assign latch_len = byp_q ? rcl_pkg::LATCH_BYP_CYC : rcl_pkg::LATCH_CYC;
    assign latch_strobe = (state == S_LATCH) &&
                          (cnt == latch_len - 1'b1);
    // Capacitor dropping below threshold while the pin is low kills bidir
    assign rpd_drop  = (state == S_SEQ) && !i_discharge_pin_high &&
                       (pin_low || drive_en);

    always_comb begin
        next_state = state;
        next_kind  = kind;
        unique case (state)
            S_RUN: begin
                if (hw_start) begin
                    next_state = S_SEQ;
                    next_kind  = rcl_pkg::RK_SHORT_HW;
                end else if (wdt_start) begin
                    next_state = S_SEQ;
                    next_kind  = rcl_pkg::RK_WATCHDOG;
                end else if (sw_start) begin
                    next_state = S_SEQ;
                    next_kind  = rcl_pkg::RK_SOFTWARE;
                end
            end
            S_SEQ: begin
                if (seq_last) begin
                    next_state = S_CHECK;
                end
            end
            S_CHECK: begin
                // Pin sampled a cycle after release so our own drive is gone
                if (pin_low) begin
                    next_state = S_WAITPIN;
                    if (kind != rcl_pkg::RK_POWERON) begin
                        next_kind = rcl_pkg::RK_LONG_HW;
                    end
                end else begin
                    next_state = S_LATCH;
                end
            end
            S_WAITPIN: begin
                if (!pin_low) begin
                    next_state = S_LATCH;
                end
            end
            S_LATCH: begin
                if (latch_strobe) begin
                    next_state = S_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            state <= S_SEQ;
            kind  <= rcl_pkg::RK_POWERON;
        end else begin
            state <= next_state;
            kind  <= next_kind;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cnt <= '0;
        end else if (state != next_state) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            byp_q <= 1'b0;
        end else if (next_state == S_LATCH && state != S_LATCH) begin
            byp_q <= i_pll_bypass;
        end
    end

    // Pin drive captured from the enable bit before the sequence clears it
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            drive_en <= 1'b0;
        end else if (seq_start) begin
            drive_en <= system_config_reg[rcl_pkg::SYS_BIDIR_BIT];
        end else if (rpd_drop || seq_last) begin
            drive_en <= 1'b0;
        end
    end

    assign o_reset_in_pin_out = 1'b0;
    assign o_reset_in_pin_oe  = drive_en && (state == S_SEQ);

    // Power-on assumes a fully discharged capacitor
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_async_reset <= 1'b1;
        end else if (hw_start) begin
            o_async_reset <= !i_discharge_pin_high;
        end else if (wdt_start || sw_start) begin
            o_async_reset <= 1'b0;
        end else if (rpd_drop) begin
            o_async_reset <= 1'b1;
        end else if (state == S_WAITPIN && !pin_low) begin
            o_async_reset <= !i_discharge_pin_high;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            pull_up_en <= 1'b0;
        end else if (seq_start) begin
            pull_up_en <= 1'b0;
        end else if (latch_strobe) begin
            pull_up_en <= system_config_reg[rcl_pkg::SYS_POWERDOWN_INTERRUPTIBLE_CFG_BIT];
        end
    end

    assign o_discharge_pull_down = pin_low;
    // Pull-up yields to the pull-down so the two never fight
    assign o_discharge_pull_up   = pull_up_en && !pin_low;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            init_done <= 1'b0;
        end else if (seq_start) begin
            init_done <= 1'b0;
        end else if (state == S_RUN && i_end_of_init_instr) begin
            init_done <= 1'b1;
        end
    end

    assign o_reset_out_pin_n = init_done;
    assign o_cpu_reset       = (state != S_RUN);

    // Register bus
    assign wr_sys = i_wr && (i_addr == rcl_pkg::OFS_SYSCFG) &&
                    (state == S_RUN);
    assign wr_bus = i_wr && (i_addr == rcl_pkg::OFS_BUSCTL0) &&
                    (state == S_RUN);

    // Enable bit only writable before end of initialisation
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            system_config_reg <= rcl_pkg::SYS_RST;
        end else if (seq_start) begin
            system_config_reg[rcl_pkg::SYS_BIDIR_BIT] <= 1'b0;
        end else if (wr_sys) begin
            system_config_reg <= i_wdata;
            if (init_done) begin
                system_config_reg[rcl_pkg::SYS_BIDIR_BIT] <=
                    system_config_reg[rcl_pkg::SYS_BIDIR_BIT];
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            bus_control_reg0 <= rcl_pkg::BUS_RST;
        end else if (latch_strobe) begin
            bus_control_reg0[rcl_pkg::BUS_ACTIVE_BIT] <=
                i_external_access_pin;
            bus_control_reg0[rcl_pkg::BUS_LATCH_BIT]  <=
                i_external_access_pin;
        end else if (wr_bus) begin
            bus_control_reg0 <= i_wdata;
        end
    end

    rcl_sampler #(
        .WIDTH (16)
    ) u_sampler (
        .i_clk_sys     (i_clk_sys),
        .i_rst         (i_rst),
        .i_strobe      (latch_strobe),
        .i_kind        (kind),
        .i_config_port (i_config_port),
        .o_latched     (latched)
    );

    assign reset_config_latch = {8'h00, latched[15:8]};
    // Bus type field is read-only and always shows the sampled bits
    assign bus_read = {bus_control_reg0[15:rcl_pkg::BUS_TYPE_LSB+2],
                       latched[7:6],
                       bus_control_reg0[rcl_pkg::BUS_TYPE_LSB-1:0]};
    assign status_read = {9'h000, init_done, o_async_reset, 2'h0,
                          3'(kind)};
    assign rd_mux =
        (i_addr == rcl_pkg::OFS_SYSCFG)  ? system_config_reg  :
        (i_addr == rcl_pkg::OFS_BUSCTL0) ? bus_read           :
        (i_addr == rcl_pkg::OFS_RSTCFG)  ? reset_config_latch :
        (i_addr == rcl_pkg::OFS_STATUS)  ? status_read        : 16'h0000;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 16'h0000;
        end else begin
            o_rdata <= i_rd ? rd_mux : 16'h0000;
        end
    end

    // Routed configuration, held in the sampler flops
    assign o_clock_option_bits   = latched[15:13];
    assign o_segment_line_select = latched[12:11];
    assign o_chip_select_count   = latched[10:9];
    assign o_write_pin_config    = latched[8];
    assign o_bootloader_select   = latched[4];
    assign o_adapt_select        = latched[1];
    assign o_emu_mode            = latched[0];

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    drive_in_seq_a: assert property (
        o_reset_in_pin_oe |-> (state == S_SEQ) && o_cpu_reset)
        else $error("reset pin driven outside the sequence");

    pin_release_a: assert property (
        seq_last |=> !o_reset_in_pin_oe && (state == S_CHECK))
        else $error("reset pin not released at sequence end");

    drive_gate_a: assert property (
        $rose(o_reset_in_pin_oe) |->
            $past(system_config_reg[rcl_pkg::SYS_BIDIR_BIT]))
        else $error("pin driven without the enable bit");

    soft_pulse_a: assert property (
        (sw_start && system_config_reg[rcl_pkg::SYS_BIDIR_BIT] &&
         i_discharge_pin_high) |=> o_reset_in_pin_oe)
        else $error("software reset gave no pulse on the pin");

    release_first_a: assert property (
        $fell(o_cpu_reset) |-> !$past(o_reset_in_pin_oe))
        else $error("cpu left reset while pin still driven");

    discharge_pd_a: assert property (
        pin_low |-> o_discharge_pull_down && !o_discharge_pull_up)
        else $error("discharge pull-down wrong while pin low");

    pull_up_end_a: assert property (
        (latch_strobe && system_config_reg[rcl_pkg::SYS_POWERDOWN_INTERRUPTIBLE_CFG_BIT])
            |=> pull_up_en)
        else $error("discharge pull-up not enabled");

    async_pick_a: assert property (
        (hw_start && !i_discharge_pin_high) |=> o_async_reset)
        else $error("low discharge pin did not pick async reset");

    power_on_async_a: assert property (
        $fell(i_rst) |-> o_async_reset && (kind == rcl_pkg::RK_POWERON))
        else $error("power-on reset not asynchronous");

    bidir_clear_a: assert property (
        $rose(o_cpu_reset) |->
            !system_config_reg[rcl_pkg::SYS_BIDIR_BIT])
        else $error("enable bit survived a reset sequence");

    // Own count of sequence cycles; a long delay would choke the tools
    logic [CW-1:0] seq_seen;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            seq_seen <= '0;
        end else if (state == S_SEQ) begin
            seq_seen <= seq_seen + 1'b1;
        end else begin
            seq_seen <= '0;
        end
    end

    seq_length_a: assert property (
        (state == S_CHECK) |-> (seq_seen == rcl_pkg::SEQ_CYC))
        else $error("internal sequence length wrong");

    latch_delay_a: assert property (
        ($changed(state) && state == S_LATCH && !byp_q) |->
            !latch_strobe ##1 !latch_strobe ##1 !latch_strobe ##1
            latch_strobe)
        else $error("config latch delay wrong");

    rstcfg_read_a: assert property (
        (i_rd && i_addr == rcl_pkg::OFS_RSTCFG) |=>
            o_rdata == {8'h00, $past(latched[15:8])})
        else $error("latch register read wrong");

    bus_active_a: assert property (
        latch_strobe |=> bus_control_reg0[rcl_pkg::BUS_ACTIVE_BIT] ==
            $past(i_external_access_pin))
        else $error("bus active bit not from access pin");

    sw_seq_c: cover property (sw_start ##1 o_reset_in_pin_oe);
    long_hw_c: cover property (state == S_WAITPIN ##1 state == S_LATCH);
    pull_up_c: cover property (latch_strobe ##1 o_discharge_pull_up);
    bypass_c: cover property (latch_strobe && byp_q);

endmodule

// File: tb/rcl_ext_model.sv
// Reset pin wiring and discharge capacitor beside the block
`timescale 1ns/1ps
module rcl_ext_model (
    input  wire logic i_clk_sys,
    input  wire logic i_pin_out,
    input  wire logic i_pin_oe,
    input  wire logic i_ext_low,
    input  wire logic i_pull_down,
    input  wire logic i_pull_up,
    output logic      o_pin,
    output logic      o_rpd_high
);
    logic [11:0] cap = 12'h000;
    // Pin has a pull-up; open drain and external switch wire-or it low
    assign o_pin      = !((i_pin_oe && !i_pin_out) || i_ext_low);
    assign o_rpd_high = cap[11];
    // Weak discharge, so a warm reset keeps the level above threshold
    always @(posedge i_clk_sys) begin
        if (i_pull_up && cap < 12'hff0)
            cap <= cap + 12'h010;
        else if (i_pull_down && !i_pull_up && cap != 12'h000)
            cap <= cap - 12'h001;
    end
endmodule

// File: tb/reset_pin_and_config_latch_tb_top.sv
// Self-checking bench of the reset pin and configuration latch
`timescale 1ns/1ps
module reset_pin_and_config_latch_tb_top;
    logic        clk, rst, ext_low, sw, wdt, eoi, byp, ea, wr, rd;
    logic [15:0] port, wdata, rdata, lat, got;
    logic [7:0]  addr;
    logic        pin, discharge_pin, out, oe, pd, pu, rout_n, cpu, asy;
    logic [2:0]  clk_opt;
    logic [1:0]  seg, cs;
    logic        write_pin_config, bootloader_select, adapt_select, emu;
    int          bad_count, n_checks, seed, n, c, o;

    rcl_top u_rcl_top (.i_clk_sys(clk), .i_rst(rst), .i_reset_in_pin(pin),
        .o_reset_in_pin_out(out), .o_reset_in_pin_oe(oe),
        .i_discharge_pin_high(discharge_pin), .o_discharge_pull_down(pd),
        .o_discharge_pull_up(pu), .o_reset_out_pin_n(rout_n),
        .i_sw_reset_req(sw), .i_wdt_reset_req(wdt),
        .i_end_of_init_instr(eoi), .i_pll_bypass(byp),
        .i_external_access_pin(ea), .i_config_port(port), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .o_cpu_reset(cpu), .o_async_reset(asy),
        .o_clock_option_bits(clk_opt), .o_segment_line_select(seg),
        .o_chip_select_count(cs), .o_write_pin_config(write_pin_config),
        .o_bootloader_select(bootloader_select), .o_adapt_select(adapt_select), .o_emu_mode(emu));

    rcl_ext_model u_rcl_ext_model (.i_clk_sys(clk), .i_pin_out(out),
        .i_pin_oe(oe), .i_ext_low(ext_low), .i_pull_down(pd),
        .i_pull_up(pu), .o_pin(pin), .o_rpd_high(discharge_pin));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, g, e);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rreg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        got = rdata;
    endtask

    // Runs one reset to its end; counts reset cycles and pin drive cycles
    task automatic go(input int h);
        c = 0;
        o = 0;
        for (n = 0; n < 6000; n++) begin
            @(posedge clk);
            sw  <= 1'b0;
            wdt <= 1'b0;
            if (c == h)
                ext_low <= 1'b0;
            #1;
            if (!cpu)
                break;
            c++;
            if (oe)
                o++;
        end
    endtask

    // Lets the capacitor charge close to full through the pull-up
    task automatic charge();
        for (n = 0; n < 1000 && u_rcl_ext_model.cap < 12'hfe0; n++)
            @(posedge clk);
    endtask

    function automatic logic [15:0] nxt(input logic [15:0] p, input int k);
        case (k)
            2: return (lat & 16'he000) | (p & 16'h1fff);
            3, 4: return (lat & 16'he003) | (p & 16'h1fc0);
            default: return p;
        endcase
    endfunction

    task automatic cmp(input int k, input logic a);
        chk({5'h00, clk_opt, seg, cs, write_pin_config, bootloader_select, adapt_select, emu},
            {5'h00, lat[15:8], lat[4], lat[1:0]});
        rreg(8'h08);
        chk(got, {8'h00, lat[15:8]});
        rreg(8'h04);
        chk({12'h000, got[10:9], got[7:6]}, {12'h000, ea, ea, lat[7:6]});
        rreg(8'h0c);
        chk({12'h000, got[5], got[2:0]}, {12'h000, a, 3'(k)});
        chk({15'h0000, asy}, {15'h0000, a});
    endtask

    // Discharge pull-down follows the reset pin at all times
    always @(negedge clk)
        if (!rst)
            chk({14'h0000, out, pd}, {15'h0000, !pin});

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #800us;
        bad_count++;
        end_sim();
    end

    initial begin
        {rst, ext_low, sw, wdt, eoi, byp, wr, rd} = 8'h80;
        {addr, wdata, bad_count, n_checks} = '0;
        seed = 32'hf3934777;
        port = 16'($random(seed));
        ea = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        go(0);
        lat = port;
        cmp(0, 1'b1);
        // Pull-up only comes on at a sequence end, so arm it first
        wreg(8'h00, 16'h0020);
        port <= 16'($random(seed));
        wdt  <= 1'b1;
        go(0);
        chk(16'(o), 16'h0000);
        chk(16'(c), 16'h0205);
        lat = nxt(port, 4);
        cmp(4, 1'b0);
        charge();
        chk({15'h0000, discharge_pin}, 16'h0001);
        wreg(8'h00, 16'h0028);
        port <= 16'($random(seed));
        ea   <= 1'($random(seed));
        sw   <= 1'b1;
        go(0);
        chk(16'(c), 16'h0205);
        chk(16'(o), 16'h0200);
        lat = nxt(port, 3);
        cmp(3, 1'b0);
        rreg(8'h00);
        chk({13'h0000, got[5:3]}, 16'h0004);
        chk({15'h0000, rout_n}, 16'h0000);
        @(posedge clk);
        eoi <= 1'b1;
        @(posedge clk);
        eoi <= 1'b0;
        wreg(8'h00, 16'h0028);
        rreg(8'h00);
        chk({14'h0000, rout_n, got[3]}, 16'h0002);
        port    <= 16'($random(seed));
        byp     <= 1'b1;
        ext_low <= 1'b1;
        go(3);
        chk(16'(c), 16'h0204);
        byp <= 1'b0;
        lat = nxt(port, 2);
        cmp(2, 1'b0);
        charge();
        port    <= 16'($random(seed));
        ext_low <= 1'b1;
        go(2600);
        lat = nxt(port, 1);
        cmp(1, 1'b1);
        chk({15'h0000, pu}, 16'h0001);
        // Capacitor is still low after the long hold: async short reset
        port    <= 16'($random(seed));
        ext_low <= 1'b1;
        go(3);
        lat = nxt(port, 2);
        cmp(2, 1'b1);
        rreg(8'h10);
        chk(got, 16'h0000);
        wreg(8'h08, 16'hffff);
        rreg(8'h08);
        chk(got, {8'h00, lat[15:8]});
        end_sim();
    end
endmodule
